// ### pkg/wff_pkg.sv
// constants shared by the weight frame formatter and its fifo
`default_nettype none
package wff_pkg;
   // apb register byte addresses
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_FORMAT = 12'h004;
   localparam logic [11:0] ADDR_COND   = 12'h008;
   localparam logic [11:0] ADDR_WEIGHT = 12'h00c;
   localparam logic [11:0] ADDR_TARE   = 12'h010;
   localparam logic [11:0] ADDR_STATUS = 12'h014;
   localparam logic [11:0] ADDR_KEYS   = 12'h018;
   // control register fields
   localparam int CTRL_CONT_BIT  = 0;
   localparam int CTRL_CRLF_BIT  = 1;
   localparam int CTRL_SUM_BIT   = 2;
   localparam int CTRL_PORT0_BIT = 3;
   localparam int CTRL_PORT1_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h1f;
   // format register: decimal point code in 2..0, increment in 4..3
   localparam logic [4:0] FORMAT_RESET = 5'h0a;
   // condition register fields
   localparam int COND_NET_BIT  = 0;
   localparam int COND_NEG_BIT  = 1;
   localparam int COND_UNST_BIT = 2;
   localparam int COND_POZ_BIT  = 3;
   localparam int COND_ERR_LSB  = 4;
   localparam logic [6:0] COND_RESET = 7'h00;
   // error codes held in the condition register
   localparam logic [2:0] ERR_NONE  = 3'h0;
   localparam logic [2:0] ERR_UNDER = 3'h1;
   localparam logic [2:0] ERR_OVER  = 3'h2;
   localparam logic [2:0] ERR_AOUT  = 3'h3;
   localparam logic [2:0] ERR_LVOLT = 3'h4;
   localparam logic [2:0] ERR_TILT  = 3'h5;
   // left aligned error texts, six characters each
   localparam logic [47:0] TXT_UNDER = 48'h554e44455220;
   localparam logic [47:0] TXT_OVER  = 48'h4f5645522020;
   localparam logic [47:0] TXT_AOUT  = 48'h412e4f555420;
   localparam logic [47:0] TXT_LVOLT = 48'h4c2d564f4c54;
   localparam logic [47:0] TXT_TILT  = 48'h54494c542020;
   // characters
   localparam logic [7:0] CH_STX   = 8'h02;
   localparam logic [7:0] CH_CR    = 8'h0d;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_PRINT = 8'h50;
   localparam logic [7:0] CH_ZEROK = 8'h5a;
   localparam logic [7:0] CH_TARE  = 8'h54;
   localparam logic [7:0] CH_CLEAR = 8'h43;
   localparam logic [7:0] CONST_FLAGS = 8'h30;
   // frame byte positions
   localparam logic [4:0] IDX_STX  = 5'd0;
   localparam logic [4:0] IDX_FMT  = 5'd1;
   localparam logic [4:0] IDX_COND = 5'd2;
   localparam logic [4:0] IDX_CONS = 5'd3;
   localparam logic [4:0] IDX_WGT  = 5'd4;
   localparam logic [4:0] IDX_TARE = 5'd10;
   localparam logic [4:0] IDX_LAST_TARE = 5'd15;
   localparam logic [4:0] IDX_CR   = 5'd16;
   localparam logic [4:0] IDX_LF   = 5'd17;
   localparam logic [4:0] IDX_SUM  = 5'd18;
   localparam int FIFO_DEPTH = 8;
endpackage
`default_nettype wire

// ### rtl/wff_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module wff_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_ff;
   logic [AW-1:0]    rdPtr_ff;
   logic [AW:0]      count_ff;
   wire              doPush;
   wire              doPop;

   // honest full and empty from the occupancy count
   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;
   assign outData  = mem[rdPtr_ff];

   // storage needs no reset
   always_ff @(posedge mclk) begin
      if (doPush) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (doPush) begin
            wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
         end
         if (doPop) begin
            rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
   end

   chk_fifo_no_overflow: assert property (@(posedge mclk) disable iff
      (!resetn) count_ff <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule
`default_nettype wire

// ### rtl/wff_frame_formatter.sv
// weight frame builder with apb registers and command letter decoder
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - frame order: start, three flag bytes, weight, tare, cr, lf, sum
// - a control bit includes or omits both cr and lf
// - a control bit enables the sum byte on frames and on commands
// - continuous frames go to every enabled port as one shared stream
// - received letters P, Z, T, C act as print, zero, tare, clear keys
// - format byte: decimal code in 2..0, increment in 4..3, bits 5,6 set
// - condition byte: net, negative, error and unstable in bits 0..3
// - condition byte bits 4,5 set, bit 6 power-on zero, bit 7 free
// - constant byte has bits 4,5 set and bits 0..3 and 6 clear
// - error conditions put their text into the weight field
// - numbers right aligned, error text left aligned
// - sum byte makes the whole frame add to zero modulo 256
module wff_frame_formatter
   import wff_pkg::*;
#(
   parameter int FIFO_WIDTH = 8,
   parameter int FIFO_DEPTH_P = wff_pkg::FIFO_DEPTH
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxData,
   output logic      [7:0]  txData,
   output logic      [1:0]  txValid,
   input  wire logic [1:0]  txReady,
   output logic             keyPrint,
   output logic             keyZero,
   output logic             keyTare,
   output logic             keyClear,
   output logic             frameBusy
);
   import wff_pkg::*;

   // software registers
   logic [4:0]  ctrl_ff;
   logic [4:0]  format_ff;
   logic [6:0]  cond_ff;
   logic [23:0] weight_ff;
   logic [23:0] tare_ff;
   logic [31:0] prdata_ff;
   logic [15:0] frameCount_ff;
   logic [15:0] cmdCount_ff;
   logic [7:0]  lastCmd_ff;
   // frame generator state
   logic        busy_ff;
   logic        pend_ff;
   logic [4:0]  idx_ff;
   logic [7:0]  sum_ff;
   logic [4:0]  snapFmt_ff;
   logic [6:0]  snapCond_ff;
   logic [23:0] snapWgt_ff;
   logic [23:0] snapTare_ff;
   // command decoder state
   logic        cmdWait_ff;
   logic [7:0]  cmdHeld_ff;
   logic [3:0]  keys_ff;

   // ascii digit with leading zero blanking up to the units position
   function automatic logic [7:0] digitChar(input logic [23:0] bcd,
                                            input logic [2:0]  pos,
                                            input logic [2:0]  units);
      logic lead;
      logic [3:0] nib;
      lead = 1'b1;
      nib  = bcd[23 - 4*pos -: 4];
      for (int j = 0; j < 6; j++) begin
         if (j < int'(pos) && bcd[23 - 4*j -: 4] != 4'h0) begin
            lead = 1'b0;
         end
      end
      if (lead && nib == 4'h0 && pos < units) begin
         digitChar = CH_SPACE;
      end else begin
         digitChar = CH_ZERO + {4'h0, nib};
      end
   endfunction

   // left aligned error text character
   function automatic logic [7:0] errChar(input logic [2:0] code,
                                          input logic [2:0] pos);
      logic [47:0] txt;
      unique case (code)
         ERR_UNDER: txt = TXT_UNDER;
         ERR_OVER:  txt = TXT_OVER;
         ERR_AOUT:  txt = TXT_AOUT;
         ERR_LVOLT: txt = TXT_LVOLT;
         ERR_TILT:  txt = TXT_TILT;
         default:   txt = {6{CH_SPACE}};
      endcase
      errChar = txt[47 - 8*pos -: 8];
   endfunction

   // apb decode; every access completes in its first access cycle
   wire wrEn     = psel & penable & pwrite;
   wire setupRd  = psel & ~penable & ~pwrite;
   wire addrHit  = (paddr == ADDR_CTRL) || (paddr == ADDR_FORMAT) ||
                   (paddr == ADDR_COND) || (paddr == ADDR_WEIGHT) ||
                   (paddr == ADDR_TARE) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_KEYS);
   wire wrWeight = wrEn && paddr == ADDR_WEIGHT;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrHit;
   assign prdata  = prdata_ff;

   // read mux, sampled in the setup cycle so prdata comes from a flop
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0;
      unique case (paddr)
         ADDR_CTRL:   rdMux = {27'h0, ctrl_ff};
         ADDR_FORMAT: rdMux = {27'h0, format_ff};
         ADDR_COND:   rdMux = {25'h0, cond_ff};
         ADDR_WEIGHT: rdMux = {8'h0, weight_ff};
         ADDR_TARE:   rdMux = {8'h0, tare_ff};
         ADDR_STATUS: rdMux = {frameCount_ff, 14'h0, pend_ff, busy_ff};
         ADDR_KEYS:   rdMux = {cmdCount_ff, 8'h0, lastCmd_ff};
         default:     rdMux = 32'h0;
      endcase
   end

   // register writes
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctrl_ff   <= CTRL_RESET;
         format_ff <= FORMAT_RESET;
         cond_ff   <= COND_RESET;
         weight_ff <= 24'h0;
         tare_ff   <= 24'h0;
         prdata_ff <= 32'h0;
      end else begin
         if (wrEn && paddr == ADDR_CTRL)   ctrl_ff   <= pwdata[4:0];
         if (wrEn && paddr == ADDR_FORMAT) format_ff <= pwdata[4:0];
         if (wrEn && paddr == ADDR_COND)   cond_ff   <= pwdata[6:0];
         if (wrWeight)                     weight_ff <= pwdata[23:0];
         if (wrEn && paddr == ADDR_TARE)   tare_ff   <= pwdata[23:0];
         if (setupRd) prdata_ff <= rdMux;
      end
   end

   wire contEn = ctrl_ff[CTRL_CONT_BIT];
   wire crlfEn = ctrl_ff[CTRL_CRLF_BIT];
   wire sumEn  = ctrl_ff[CTRL_SUM_BIT];
   wire [1:0] portEn = {ctrl_ff[CTRL_PORT1_BIT], ctrl_ff[CTRL_PORT0_BIT]};

   // snapshot fields used while the frame is being sent
   wire [2:0] dpCode  = snapFmt_ff[2:0];
   wire [2:0] errCode = snapCond_ff[COND_ERR_LSB +: 3];
   wire       errOn   = (errCode != ERR_NONE);
   wire [2:0] decs    = (dpCode >= 3'd3) ? dpCode - 3'd2 : 3'd0;
   wire [2:0] unitsP  = 3'd5 - decs;
   wire [2:0] wPos    = 3'(idx_ff - IDX_WGT);
   wire [2:0] tPos    = 3'(idx_ff - IDX_TARE);
   wire [7:0] fmtByte  = {1'b0, 1'b1, 1'b1, snapFmt_ff[4:3], dpCode};
   // condition flags, fixed and power-on bits
   wire [7:0] condByte = {1'b0, snapCond_ff[COND_POZ_BIT], 1'b1, 1'b1,
                          snapCond_ff[COND_UNST_BIT], errOn,
                          snapCond_ff[COND_NEG_BIT],
                          snapCond_ff[COND_NET_BIT]};

   // byte mux for the current frame position
   logic [7:0] curByte;
   always_comb begin
      curByte = CH_SPACE;
      if (idx_ff == IDX_STX) begin
         curByte = CH_STX;
      end else if (idx_ff == IDX_FMT) begin
         curByte = fmtByte;
      end else if (idx_ff == IDX_COND) begin
         curByte = condByte;
      end else if (idx_ff == IDX_CONS) begin
         curByte = CONST_FLAGS;
      end else if (idx_ff < IDX_TARE) begin
         // error text left aligned, digits right aligned
         curByte = errOn ? errChar(errCode, wPos)
                         : digitChar(snapWgt_ff, wPos, unitsP);
      end else if (idx_ff <= IDX_LAST_TARE) begin
         curByte = digitChar(snapTare_ff, tPos, unitsP);
      end else if (idx_ff == IDX_CR) begin
         curByte = CH_CR;
      end else if (idx_ff == IDX_LF) begin
         curByte = CH_LF;
      end else begin
         // sum closes the frame to zero
         curByte = 8'h00 - sum_ff;
      end
   end

   // next position, skipping cr/lf and sum when disabled
   logic [4:0] nxtIdx;
   logic       lastByte;
   always_comb begin
      nxtIdx   = idx_ff + 5'd1;
      lastByte = 1'b0;
      if (idx_ff == IDX_LAST_TARE && !crlfEn) begin
         nxtIdx   = IDX_SUM;
         lastByte = !sumEn;
      end else if (idx_ff == IDX_LF) begin
         lastByte = !sumEn;
      end else if (idx_ff == IDX_SUM) begin
         lastByte = 1'b1;
      end
   end

   wire fifoInReady;
   wire fifoOutValid;
   wire [7:0] fifoOutData;
   wire       txAllReady;
   // the generator stalls while the fifo is full
   wire push  = busy_ff & fifoInReady;
   wire start = ~busy_ff & pend_ff;

   // a weight update requests a frame only while the continuous bit is set; the update wins over the clear
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= (wrWeight & contEn) | (pend_ff & ~start);
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         busy_ff       <= 1'b0;
         idx_ff        <= IDX_STX;
         sum_ff        <= 8'h00;
         frameCount_ff <= 16'h0;
      end else if (start) begin
         busy_ff <= 1'b1;
         idx_ff  <= IDX_STX;
         sum_ff  <= 8'h00;
      end else if (push) begin
         idx_ff <= nxtIdx;
         sum_ff <= sum_ff + curByte;
         if (lastByte) begin
            busy_ff       <= 1'b0;
            frameCount_ff <= frameCount_ff + 16'h1;
         end
      end
   end

   // frame contents are frozen at the start of each frame
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         snapFmt_ff  <= FORMAT_RESET;
         snapCond_ff <= COND_RESET;
         snapWgt_ff  <= 24'h0;
         snapTare_ff <= 24'h0;
      end else if (start) begin
         snapFmt_ff  <= format_ff;
         snapCond_ff <= cond_ff;
         snapWgt_ff  <= weight_ff;
         snapTare_ff <= tare_ff;
      end
   end

   wff_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH_P)
   ) i_wff_fifo (
      .mclk     (mclk),
      .resetn   (resetn),
      .inValid  (busy_ff),
      .inReady  (fifoInReady),
      .inData   (curByte),
      .outValid (fifoOutValid),
      .outReady (txAllReady),
      .outData  (fifoOutData)
   );

   // one stream to all enabled ports; a byte leaves only when every
   // enabled port takes it, so no port sees a duplicate or a gap
   assign txAllReady = &(txReady | ~portEn);
   assign txData     = fifoOutData;
   assign txValid[0] = fifoOutValid & portEn[0] & (txReady[1] | ~portEn[1]);
   assign txValid[1] = fifoOutValid & portEn[1] & (txReady[0] | ~portEn[0]);
   assign frameBusy  = busy_ff;

   wire isCmd = (rxData == CH_PRINT) || (rxData == CH_ZEROK) ||
                (rxData == CH_TARE)  || (rxData == CH_CLEAR);
   // with sum enabled, a letter must be followed by its sum byte
   wire sumOk   = (8'(cmdHeld_ff + rxData) == 8'h00);
   wire fireNow = rxValid & ((~sumEn & ~cmdWait_ff & isCmd) |
                             (cmdWait_ff & sumOk));
   wire [7:0] fireCode = cmdWait_ff ? cmdHeld_ff : rxData;

   // command decoder; key outputs are one-cycle pulses
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cmdWait_ff  <= 1'b0;
         cmdHeld_ff  <= 8'h00;
         keys_ff     <= 4'h0;
         lastCmd_ff  <= 8'h00;
         cmdCount_ff <= 16'h0;
      end else begin
         keys_ff <= 4'h0;
         if (rxValid) begin
            cmdWait_ff <= ~cmdWait_ff & sumEn & isCmd;
            cmdHeld_ff <= rxData;
         end
         if (fireNow) begin
            keys_ff     <= {fireCode == CH_CLEAR, fireCode == CH_TARE,
                            fireCode == CH_ZEROK, fireCode == CH_PRINT};
            lastCmd_ff  <= fireCode;
            cmdCount_ff <= cmdCount_ff + 16'h1;
         end
      end
   end
   assign keyPrint = keys_ff[0];
   assign keyZero  = keys_ff[1];
   assign keyTare  = keys_ff[2];
   assign keyClear = keys_ff[3];

   // checks next to the logic they guard
   chk_stx_first_byte: assert property (@(posedge mclk)
      disable iff (!resetn) start |=> idx_ff == IDX_STX && curByte == CH_STX)
      else $error("frame does not open with start byte");
   chk_fmt_fixed_bits: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_FMT |->
      curByte[6:3] == {2'b11, snapFmt_ff[4:3]} && curByte[2:0] == dpCode)
      else $error("format byte layout wrong");
   chk_cond_flag_bits: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_COND |->
      curByte[2] == errOn && curByte[0] == snapCond_ff[COND_NET_BIT])
      else $error("condition flags wrong");
   chk_cond_fixed_bits: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_COND |->
      curByte[5:4] == 2'b11) else $error("condition byte fixed bits wrong");
   chk_const_byte_val: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_CONS |->
      curByte[6:0] == 7'h30) else $error("constant flags byte wrong");
   chk_crlf_omitted: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_LAST_TARE && !crlfEn &&
      sumEn |=> idx_ff == IDX_SUM)
      else $error("cr lf not skipped");
   chk_sum_closes_zero: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_SUM |->
      8'(sum_ff + curByte) == 8'h00) else $error("frame sum not zero");
   chk_err_text_left: assert property (@(posedge mclk)
      disable iff (!resetn) push && idx_ff == IDX_WGT && errCode == ERR_TILT
      |-> curByte == 8'h54) else $error("error text not in weight field");
   chk_key_print_pulse: assert property (@(posedge mclk)
      disable iff (!resetn) rxValid && !sumEn && !cmdWait_ff &&
      rxData == CH_PRINT |=> keyPrint ##1 (!keyPrint || $past(rxValid)))
      else $error("print key not pulsed");
   chk_ports_same_stream: assert property (@(posedge mclk)
      disable iff (!resetn) portEn == 2'b11 && txReady == 2'b11 |->
      txValid[0] == txValid[1]) else $error("ports do not share the stream");
   chk_frame_on_update: assert property (@(posedge mclk)
      disable iff (!resetn) wrWeight && contEn |=> pend_ff || busy_ff)
      else $error("weight update did not request a frame");
endmodule
`default_nettype wire

// ### verif/wff_host_model.sv
// host side sink: collects frame bytes from both ports, can stall
`timescale 1ns/1ps
`default_nettype none
module wff_host_model (
   input  wire logic       mclk,
   input  wire logic       slow,
   input  wire logic [7:0] txData,
   input  wire logic [1:0] txValid,
   output logic      [1:0] txReady
);
   logic [7:0] q0[$];
   logic [7:0] q1[$];
   logic [1:0] phase = 2'h0;
   // ports stall on different phases so the fifo backs up and refuses
   assign txReady = slow ? {phase != 2'h1, phase == 2'h0} : 2'h3;
   // one stream captured on every port
   always @(posedge mclk) begin
      phase <= phase + 2'h1;
      if (txValid[0] && txReady[0])
         q0.push_back(txData);
      if (txValid[1] && txReady[1])
         q1.push_back(txData);
   end
endmodule
`default_nettype wire

// ### verif/wff_frame_formatter_tb.sv
// self-checking bench for the weight frame formatter
`timescale 1ns/1ps
`default_nettype none
module wff_frame_formatter_tb;
   import wff_pkg::*;
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
   logic        rxValid, frameBusy, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  rxData, txData;
   logic [1:0]  txValid, txReady;
   logic [3:0]  keys;
   logic [7:0]  expq[$];
   logic [47:0] txt[1:5] = '{TXT_UNDER, TXT_OVER, TXT_AOUT, TXT_LVOLT,
                             TXT_TILT};
   int          errTotal = 0;
   int          samplesChecked = 0;

   wff_frame_formatter i_wff_frame_formatter (
      .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxValid(rxValid), .rxData(rxData), .txData(txData),
      .txValid(txValid), .txReady(txReady), .keyPrint(keys[3]),
      .keyZero(keys[2]), .keyTare(keys[1]), .keyClear(keys[0]),
      .frameBusy(frameBusy));
   wff_host_model i_wff_host_model (.mclk(mclk), .slow(slow),
      .txData(txData), .txValid(txValid), .txReady(txReady));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                  seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic expErr);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      check(pslverr, expErr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // six characters, leading zeros blank up to the units position
   task automatic field(input logic [23:0] v, input int u);
      logic lead;
      lead = 1'b1;
      for (int i = 0; i < 6; i++) begin
         if (v[23-4*i -: 4] != 4'h0 || i >= u)
            lead = 1'b0;
         expq.push_back(lead ? CH_SPACE : {4'h3, v[23-4*i -: 4]});
      end
   endtask

   // program, trigger by a weight write, compare both ports
   task automatic frame(input logic [4:0] c, input logic [4:0] f,
                        input logic [6:0] k, input logic [23:0] w, t);
      logic [7:0] s;
      int u;
      apb(1'b1, ADDR_CTRL, 32'(c), 1'b0);
      apb(1'b1, ADDR_FORMAT, 32'(f), 1'b0);
      apb(1'b1, ADDR_COND, 32'(k), 1'b0);
      apb(1'b1, ADDR_TARE, 32'(t), 1'b0);
      apb(1'b1, ADDR_WEIGHT, 32'(w), 1'b0);
      u = 5 - ((f[2:0] >= 3'h3) ? int'(f[2:0]) - 2 : 0);
      expq = '{CH_STX, {3'h3, f}, {1'b0, k[3], 2'h3, k[2], k[6:4] != 3'h0,
              k[1:0]}, CONST_FLAGS};
      for (int i = 0; i < 6; i++)
         if (k[6:4] != 3'h0)
            expq.push_back(txt[k[6:4]][47-8*i -: 8]);
      if (k[6:4] == 3'h0)
         field(w, u);
      field(t, u);
      if (c[1])
         expq = {expq, CH_CR, CH_LF};
      s = 8'h00;
      foreach (expq[i])
         s -= expq[i];
      if (c[2])
         expq.push_back(s);
      for (int i = 0; i < 3000; i++) begin
         @(posedge mclk);
         if (i_wff_host_model.q0.size() >= expq.size() && frameBusy === 1'b0)
            break;
      end
      repeat (6) @(posedge mclk);
      check(frameBusy, 1'b0);
      check(i_wff_host_model.q0.size(), expq.size());
      foreach (expq[i])
         check(i_wff_host_model.q0[i], expq[i]);
      check(i_wff_host_model.q1.size(), c[4] ? expq.size() : 0);
      foreach (expq[i])
         if (c[4])
            check(i_wff_host_model.q1[i], expq[i]);
      i_wff_host_model.q0.delete();
      i_wff_host_model.q1.delete();
   endtask

   // one received byte, key pulses judged one cycle later
   task automatic cmd(input logic [7:0] b, input logic [3:0] exp);
      @(posedge mclk);
      rxValid <= 1'b1;
      rxData <= b;
      @(posedge mclk);
      rxValid <= 1'b0;
      #1 check(keys, exp);
   endtask

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // watchdog for a hung handshake
   initial begin
      repeat (40000) @(posedge mclk);
      errTotal++;
      tally_and_finish();
   end

   initial begin
      {resetn, psel, penable, pwrite, rxValid, slow} = 6'h0;
      {paddr, pwdata, rxData} = '0;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0, 1'b0);
      check(rd, 32'h1f);
      apb(1'b0, ADDR_FORMAT, 32'h0, 1'b0);
      check(rd, 32'h0a);
      apb(1'b1, 12'h01c, 32'h5, 1'b1);
      apb(1'b0, 12'h01c, 32'h0, 1'b1);
      check(rd, 32'h0);
      frame(5'h1f, 5'h0a, 7'h00, 24'h000750, 24'h000250);
      for (int c = 0; c < 8; c++)
         frame(5'h1f, {2'(c % 3 + 1), 3'(c)}, 7'(c * 5 % 16), 24'h000305,
               24'h0);
      for (int e = 1; e < 6; e++)
         frame(5'h1f, 5'h0b, {3'(e), 4'h1}, 24'h123456, 24'h000010);
      frame(5'h19, 5'h0a, 7'h02, 24'h999999, 24'h000001);
      frame(5'h1b, 5'h0a, 7'h00, 24'h010000, 24'h0);
      frame(5'h1d, 5'h0a, 7'h00, 24'h000042, 24'h0);
      frame(5'h0f, 5'h0a, 7'h00, 24'h000750, 24'h0);
      slow <= 1'b1;
      frame(5'h1f, 5'h12, 7'h08, 24'h543210, 24'h000123);
      slow <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h1b, 1'b0);
      cmd(CH_PRINT, 4'h8);
      cmd(CH_ZEROK, 4'h4);
      cmd(CH_TARE, 4'h2);
      cmd(CH_CLEAR, 4'h1);
      cmd(8'h41, 4'h0);
      apb(1'b1, ADDR_CTRL, 32'h1f, 1'b0);
      cmd(CH_PRINT, 4'h0);
      cmd(8'hb0, 4'h8);
      cmd(CH_TARE, 4'h0);
      cmd(8'h00, 4'h0);
      // five accepted letters, the last one print
      apb(1'b0, ADDR_KEYS, 32'h0, 1'b0);
      check(rd, 32'h00050050);
      // nineteen frames sent, generator idle
      apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
      check(rd, 32'h00130000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
